// ==== core/ccpt_defines.svh ====
// How it works
// - Standard unit has 16-bit counter, four channels
// - Wide unit is identical with 32-bit counter
// - Each channel runs capture, compare or PWM
// - Capture latches counter on selected input edge
// - Compare output shows counter against programmed threshold
// - PWM waveform follows successive compare values
// - Dead-time insertion exists only in unit zero
// - Counts clock or events, emits routing triggers
`ifndef CCPT_DEFINES_SVH
`define CCPT_DEFINES_SVH

// ----------------------------------------------------------------
// Register byte addresses
// ----------------------------------------------------------------
`define CCPT_A_CTRL   8'h00
`define CCPT_A_STS    8'h04
`define CCPT_A_MSK    8'h08
`define CCPT_A_CNT    8'h0C
`define CCPT_A_DT     8'h10
`define CCPT_CH_PAGE  3'h1
`define CCPT_CH_VSEL  2

// ----------------------------------------------------------------
// Field positions and widths
// ----------------------------------------------------------------
`define CCPT_CTRL_EN   0
`define CCPT_CTRL_SRC  1
`define CCPT_CTRL_DTEN 2
`define CCPT_STS_OVF   0
`define CCPT_STS_CH0   1
`define CCPT_NSTS      5
`define CCPT_DT_W      8
`define CCPT_CFG_W     3
`define CCPT_MAX_CH    4

`endif

// ==== core/ccpt_pkg.sv ====
`default_nettype none
// ----------------------------------------------------------------
// Shared types
// ----------------------------------------------------------------
package ccpt_pkg;
  // Channel operating mode, field order matches config word bits
  typedef enum logic [1:0] {ccpt_off, ccpt_capture, ccpt_compare, ccpt_pwm} ccpt_mode_t;
  // Channel configuration word
  typedef struct packed {
    logic       falling;  // Capture on falling edge when set
    ccpt_mode_t mode;     // Operating mode
  } ccpt_chcfg_t;
  // Register bus request
  typedef struct packed {
    logic        wr;      // Write strobe
    logic        rd;      // Read strobe
    logic [7:0]  addr;    // Byte address
    logic [31:0] wdata;   // Write data
  } ccpt_bus_t;
endpackage
`default_nettype wire

// ==== core/ccpt_channel.sv ====
`default_nettype none
// ----------------------------------------------------------------
// One capture / compare / PWM channel
// ----------------------------------------------------------------
module ccpt_channel #(
  parameter int CNT_W = 16
) (
  // Clock and reset
  input  wire logic                 clk_sys,
  input  wire logic                 resetn,
  input  wire logic                 ce,
  // Counter view
  input  wire logic [CNT_W-1:0]     cnt,
  input  wire logic                 tick,
  input  wire logic                 wrap,
  input  wire logic                 cap_evt,
  // Software side
  input  wire ccpt_pkg::ccpt_chcfg_t cfg,
  input  wire logic                 wr_val,
  input  wire logic [CNT_W-1:0]     wdata,
  // Results
  output logic [CNT_W-1:0]          val,
  output logic                      out,
  output logic                      flag
);
  // Channel state
  typedef struct packed {
    logic [CNT_W-1:0] val;     // Threshold or captured value
    logic [CNT_W-1:0] shadow;  // PWM threshold in use this period
    logic             out;     // Channel output
    logic             flag;    // One-cycle event pulse
  } ccpt_ch_t;

  ccpt_ch_t s_r;  // Registered state
  ccpt_ch_t s_nxt; // Next state

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    s_nxt      = s_r;
    s_nxt.flag = 1'b0;
    if (wr_val) begin
      s_nxt.val = wdata;
    end
    case (cfg.mode)
      ccpt_pkg::ccpt_capture: begin
        // Capture beats a software write in the same cycle
        s_nxt.out = 1'b0;
        if (cap_evt) begin
          s_nxt.val  = cnt;
          s_nxt.flag = 1'b1;
        end
      end
      ccpt_pkg::ccpt_compare: begin
        s_nxt.out = (cnt >= s_r.val);
        if (tick && (cnt == s_r.val)) begin
          s_nxt.flag = 1'b1;
        end
      end
      ccpt_pkg::ccpt_pwm: begin
        // Reload only at wrap so a period never sees a torn value
        s_nxt.out = (cnt < s_r.shadow);
        if (wrap) begin
          s_nxt.shadow = s_r.val;
        end
        if (tick && (cnt == s_r.shadow)) begin
          s_nxt.flag = 1'b1;
        end
      end
      default: begin
        s_nxt.out = 1'b0;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      s_r <= '0;
    end else if (ce) begin
      s_r <= s_nxt;
    end
  end

  assign val  = s_r.val;
  assign out  = s_r.out;
  assign flag = s_r.flag;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_cap_latch: assert property (@(posedge clk_sys) disable iff (!resetn)
    ce && cfg.mode == ccpt_pkg::ccpt_capture && cap_evt |=> s_r.val == $past(cnt) && s_r.flag)
    else $error("capture did not latch counter");
  a_cmp_out: assert property (@(posedge clk_sys) disable iff (!resetn)
    ce && cfg.mode == ccpt_pkg::ccpt_compare |=> s_r.out == ($past(cnt) >= $past(s_r.val)))
    else $error("compare output wrong");
  a_pwm_reload: assert property (@(posedge clk_sys) disable iff (!resetn)
    ce && cfg.mode == ccpt_pkg::ccpt_pwm && wrap |=> s_r.shadow == $past(s_r.val))
    else $error("pwm threshold not reloaded at wrap");
  a_off_quiet: assert property (@(posedge clk_sys) disable iff (!resetn)
    ce && cfg.mode == ccpt_pkg::ccpt_off |=> !s_r.out && !s_r.flag)
    else $error("idle channel active");
endmodule // ccpt_channel
`default_nettype wire

// ==== core/ccpt_deadtime.sv ====
`default_nettype none
// ----------------------------------------------------------------
// Complementary output pair with dead-time insertion
// ----------------------------------------------------------------
module ccpt_deadtime #(
  parameter int DT_W = 8
) (
  // Clock and reset
  input  wire logic            clk_sys,
  input  wire logic            resetn,
  input  wire logic            ce,
  // Control
  input  wire logic            en,
  input  wire logic [DT_W-1:0] len,
  input  wire logic            lvl,
  // Output pair
  output logic                 hi,
  output logic                 lo
);
  // Pair state
  typedef struct packed {
    logic            prev;  // Level seen last cycle
    logic [DT_W-1:0] cnt;   // Dead cycles left
    logic            hi;    // High-side drive
    logic            lo;    // Low-side drive
  } ccpt_dt_t;

  ccpt_dt_t s_r;   // Registered state
  ccpt_dt_t s_nxt; // Next state

  // ----------------------------------------------------------------
  // Next state: both sides off for len+1 cycles after each edge
  // ----------------------------------------------------------------
  always_comb begin
    s_nxt      = s_r;
    s_nxt.prev = lvl;
    if (!en) begin
      s_nxt.hi  = lvl;
      s_nxt.lo  = !lvl;
      s_nxt.cnt = '0;
    end else if (lvl != s_r.prev) begin
      // Break before make, avoids shoot-through in the bridge
      s_nxt.hi  = 1'b0;
      s_nxt.lo  = 1'b0;
      s_nxt.cnt = len;
    end else if (s_r.cnt != '0) begin
      s_nxt.cnt = s_r.cnt - 1'b1;
    end else begin
      s_nxt.hi = lvl;
      s_nxt.lo = !lvl;
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      s_r <= '0;
    end else if (ce) begin
      s_r <= s_nxt;
    end
  end

  assign hi = s_r.hi;
  assign lo = s_r.lo;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_dt_overlap: assert property (@(posedge clk_sys) disable iff (!resetn)
    !(s_r.hi && s_r.lo))
    else $error("both sides driven at once");
  a_dt_gap: assert property (@(posedge clk_sys) disable iff (!resetn)
    ce && en && (lvl != s_r.prev) |=> !s_r.hi && !s_r.lo)
    else $error("no dead gap after edge");
endmodule // ccpt_deadtime
`default_nettype wire

// ==== core/ccpt_timer.sv ====
// The implementer's own choices: the address map and strobed register access.
`include "ccpt_defines.svh"
`default_nettype none
// ----------------------------------------------------------------
// Capture / compare / PWM timer unit
// ----------------------------------------------------------------
module ccpt_timer #(
  parameter int CNT_W   = 16,  // 16 standard, 32 for wide_counter_unit
  parameter int NUM_CH  = 4,   // Channels fitted, 1 to 4
  parameter int UNIT_ID = 0    // Unit zero carries dead-time logic
) (
  // Clock and reset
  input  wire logic                 clk_sys,
  input  wire logic                 resetn,
  input  wire logic                 ce,
  // Register port
  input  wire ccpt_pkg::ccpt_bus_t  bus_req,
  output logic [31:0]               rdata,
  output logic                      irq,
  // Pins from outside the clock domain
  input  wire logic [NUM_CH-1:0]    cap_pin,
  input  wire logic                 evt_pin,
  // Channel outputs
  output logic [NUM_CH-1:0]         ch_out,
  output logic [NUM_CH-1:0]         dt_hi,
  output logic [NUM_CH-1:0]         dt_lo,
  // Triggers to the event_routing_network
  output logic                      evt_ovf,
  output logic [NUM_CH-1:0]         evt_ch
);
  // ----------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------
  if (CNT_W != 16 && CNT_W != 32) begin : g_bad_w
    $error("CNT_W must be 16 or 32");
  end
  if (NUM_CH < 1 || NUM_CH > `CCPT_MAX_CH) begin : g_bad_ch
    $error("NUM_CH must be 1 to 4");
  end
  if (UNIT_ID < 0) begin : g_bad_id
    $error("UNIT_ID must not be negative");
  end

  // Unit state
  typedef struct packed {
    logic                        en;     // Counter runs
    logic                        src;    // Count events instead of clocks
    logic                        dten;   // Dead-time on
    logic [`CCPT_DT_W-1:0]       dt;     // Dead-time length
    logic [`CCPT_NSTS-1:0]       sts;    // Sticky event flags
    logic [`CCPT_NSTS-1:0]       msk;    // Interrupt mask
    logic [CNT_W-1:0]            cnt;    // Main counter
    logic [NUM_CH-1:0]           c1;     // Capture pin sync stage 1
    logic [NUM_CH-1:0]           c2;     // Capture pin sync stage 2
    logic [NUM_CH-1:0]           c3;     // Capture pin history
    logic                        e1;     // Event pin sync stage 1
    logic                        e2;     // Event pin sync stage 2
    logic                        e3;     // Event pin history
    ccpt_pkg::ccpt_chcfg_t [NUM_CH-1:0] cfg; // Channel configuration
    logic [31:0]                 rdata;  // Read data
    logic                        irq;    // Interrupt
    logic                        ovf;    // Overflow trigger pulse
  } ccpt_st_t;

  ccpt_st_t s_r;    // Registered state
  ccpt_st_t s_nxt;  // Next state

  // Decode and datapath helpers
  logic                     tick;     // Counter advances this cycle
  logic                     wrap;     // Counter at all ones and advancing
  logic                     is_ch;    // Address in channel page
  logic [1:0]               chsel;    // Addressed channel
  logic [NUM_CH-1:0]        cap_evt;  // Selected capture edge
  logic [NUM_CH-1:0]        wr_val;   // Channel value write
  logic [`CCPT_NSTS-1:0]    set;      // Events this cycle
  logic [`CCPT_NSTS-1:0]    clr;      // Write-one-to-clear bits
  logic [NUM_CH-1:0]        ch_flag;  // Channel event pulses
  logic [NUM_CH-1:0]        ch_lvl;   // Channel outputs
  logic [CNT_W-1:0]         ch_val [NUM_CH]; // Channel values

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Zero-extend a counter-wide value to a bus word
  function automatic logic [31:0] ccpt_ext(input logic [CNT_W-1:0] v);
    logic [31:0] r;
    r            = '0;
    r[CNT_W-1:0] = v;
    return r;
  endfunction

  // Address hit test for a fixed register
  function automatic logic ccpt_hit(input logic [7:0] a, input logic [7:0] reg_a);
    return a == reg_a;
  endfunction

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    s_nxt   = s_r;
    is_ch   = bus_req.addr[7:5] == `CCPT_CH_PAGE;
    chsel   = bus_req.addr[4:3];
    set     = '0;
    clr     = '0;
    cap_evt = '0;
    wr_val  = '0;

    // Pin synchronisers: stage 1 feeds stage 2 only
    s_nxt.c1 = cap_pin;
    s_nxt.c2 = s_r.c1;
    s_nxt.c3 = s_r.c2;
    s_nxt.e1 = evt_pin;
    s_nxt.e2 = s_r.e1;
    s_nxt.e3 = s_r.e2;

    // Count clocks or rising edges of the event pin
    tick = s_r.en && (s_r.src ? (s_r.e2 && !s_r.e3) : 1'b1);
    wrap = tick && (s_r.cnt == '1);
    if (tick) begin
      s_nxt.cnt = s_r.cnt + 1'b1;
    end
    s_nxt.ovf = wrap;

    // Edge select per channel
    for (int i = 0; i < NUM_CH; i++) begin
      if (s_r.cfg[i].falling) begin
        cap_evt[i] = !s_r.c2[i] && s_r.c3[i];
      end else begin
        cap_evt[i] = s_r.c2[i] && !s_r.c3[i];
      end
      wr_val[i] = bus_req.wr && is_ch && (chsel == 2'(i)) && bus_req.addr[`CCPT_CH_VSEL];
      set[`CCPT_STS_CH0 + i] = ch_flag[i];
    end
    set[`CCPT_STS_OVF] = wrap;

    // Register writes
    if (bus_req.wr) begin
      if (ccpt_hit(bus_req.addr, `CCPT_A_CTRL)) begin
        s_nxt.en   = bus_req.wdata[`CCPT_CTRL_EN];
        s_nxt.src  = bus_req.wdata[`CCPT_CTRL_SRC];
        s_nxt.dten = bus_req.wdata[`CCPT_CTRL_DTEN];
      end
      if (ccpt_hit(bus_req.addr, `CCPT_A_STS)) begin
        clr = bus_req.wdata[`CCPT_NSTS-1:0];
      end
      if (ccpt_hit(bus_req.addr, `CCPT_A_MSK)) begin
        s_nxt.msk = bus_req.wdata[`CCPT_NSTS-1:0];
      end
      if (ccpt_hit(bus_req.addr, `CCPT_A_DT)) begin
        s_nxt.dt = bus_req.wdata[`CCPT_DT_W-1:0];
      end
      for (int i = 0; i < NUM_CH; i++) begin
        if (is_ch && (chsel == 2'(i)) && !bus_req.addr[`CCPT_CH_VSEL]) begin
          s_nxt.cfg[i] = ccpt_pkg::ccpt_chcfg_t'(bus_req.wdata[`CCPT_CFG_W-1:0]);
        end
      end
    end

    // A new event outweighs a clear in the same cycle
    s_nxt.sts = (s_r.sts & ~clr) | set;
    s_nxt.irq = |(s_nxt.sts & s_nxt.msk);

    // Read data, valid in the cycle after the strobe only
    s_nxt.rdata = '0;
    if (bus_req.rd) begin
      if (ccpt_hit(bus_req.addr, `CCPT_A_CTRL)) begin
        s_nxt.rdata[`CCPT_CTRL_EN]   = s_r.en;
        s_nxt.rdata[`CCPT_CTRL_SRC]  = s_r.src;
        s_nxt.rdata[`CCPT_CTRL_DTEN] = s_r.dten;
      end
      if (ccpt_hit(bus_req.addr, `CCPT_A_STS)) begin
        s_nxt.rdata[`CCPT_NSTS-1:0] = s_r.sts;
      end
      if (ccpt_hit(bus_req.addr, `CCPT_A_MSK)) begin
        s_nxt.rdata[`CCPT_NSTS-1:0] = s_r.msk;
      end
      if (ccpt_hit(bus_req.addr, `CCPT_A_CNT)) begin
        s_nxt.rdata = ccpt_ext(s_r.cnt);
      end
      if (ccpt_hit(bus_req.addr, `CCPT_A_DT)) begin
        s_nxt.rdata[`CCPT_DT_W-1:0] = s_r.dt;
      end
      for (int i = 0; i < NUM_CH; i++) begin
        if (is_ch && (chsel == 2'(i))) begin
          if (bus_req.addr[`CCPT_CH_VSEL]) begin
            s_nxt.rdata = ccpt_ext(ch_val[i]);
          end else begin
            s_nxt.rdata[`CCPT_CFG_W-1:0] = s_r.cfg[i];
          end
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // State register, frozen while ce is low
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      s_r <= '0;
    end else if (ce) begin
      s_r <= s_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Channels
  // ----------------------------------------------------------------
  for (genvar g = 0; g < NUM_CH; g++) begin : g_ch
    ccpt_channel #(
      .CNT_W (CNT_W)
    ) u_ch (
      .clk_sys (clk_sys),
      .resetn  (resetn),
      .ce      (ce),
      .cnt     (s_r.cnt),
      .tick    (tick),
      .wrap    (wrap),
      .cap_evt (cap_evt[g]),
      .cfg     (s_r.cfg[g]),
      .wr_val  (wr_val[g]),
      .wdata   (bus_req.wdata[CNT_W-1:0]),
      .val     (ch_val[g]),
      .out     (ch_lvl[g]),
      .flag    (ch_flag[g])
    );
  end

  // ----------------------------------------------------------------
  // Dead-time pairs: fitted in unit zero only, saves area elsewhere
  // ----------------------------------------------------------------
  if (UNIT_ID == 0) begin : g_dt
    for (genvar g = 0; g < NUM_CH; g++) begin : g_pair
      ccpt_deadtime #(
        .DT_W (`CCPT_DT_W)
      ) u_dt (
        .clk_sys (clk_sys),
        .resetn  (resetn),
        .ce      (ce),
        .en      (s_r.dten),
        .len     (s_r.dt),
        .lvl     (ch_lvl[g]),
        .hi      (dt_hi[g]),
        .lo      (dt_lo[g])
      );
    end
  end else begin : g_nodt
    assign dt_hi = ch_lvl;
    assign dt_lo = '0;
  end

  // Outputs
  assign rdata   = s_r.rdata;
  assign irq     = s_r.irq;
  assign evt_ovf = s_r.ovf;
  assign ch_out  = ch_lvl;
  assign evt_ch  = ch_flag;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_cnt_wrap: assert property (@(posedge clk_sys) disable iff (!resetn)
    ce && wrap |=> s_r.cnt == '0 && s_r.ovf && s_r.sts[`CCPT_STS_OVF])
    else $error("counter wrap or overflow flag wrong");
  a_cnt_step: assert property (@(posedge clk_sys) disable iff (!resetn)
    ce && tick |=> s_r.cnt == CNT_W'($past(s_r.cnt) + 1'b1))
    else $error("counter did not step by one");
  a_evt_count: assert property (@(posedge clk_sys) disable iff (!resetn)
    ce && s_r.src && !(s_r.e2 && !s_r.e3) |=> $stable(s_r.cnt))
    else $error("counter moved without event");
  a_ovf_trig: assert property (@(posedge clk_sys) disable iff (!resetn)
    s_r.ovf && $past(ce) |-> $past(s_r.cnt) == '1 && $past(s_r.en))
    else $error("overflow trigger without wrap");
  a_sts_sticky: assert property (@(posedge clk_sys) disable iff (!resetn)
    ce && s_r.sts[`CCPT_STS_OVF] && !(bus_req.wr && ccpt_hit(bus_req.addr, `CCPT_A_STS)
    && bus_req.wdata[`CCPT_STS_OVF]) |=> s_r.sts[`CCPT_STS_OVF])
    else $error("overflow flag lost");
  a_irq_level: assert property (@(posedge clk_sys) disable iff (!resetn)
    s_r.irq == |(s_r.sts & s_r.msk))
    else $error("interrupt does not follow flags");
  a_read_cnt: assert property (@(posedge clk_sys) disable iff (!resetn)
    ce && bus_req.rd && ccpt_hit(bus_req.addr, `CCPT_A_CNT) |=> s_r.rdata == ccpt_ext($past(s_r.cnt)))
    else $error("counter read back wrong");
endmodule // ccpt_timer
`default_nettype wire

// ==== verification/ccpt_route_model.sv ====
`default_nettype none
// ----------------------------------------------------------------
// Event routing network stand-in
// ----------------------------------------------------------------
module ccpt_route_model (
  // Clock and reset
  input  wire logic       clk_sys,
  input  wire logic       resetn,
  // Triggers from the timer
  input  wire logic       evt_ovf,
  input  wire logic [3:0] evt_ch,
  // Burst request from the bench
  input  wire logic [7:0] burst,
  input  wire logic       go,
  // Event line and tallies
  output logic            evt_pin,
  output logic [15:0]     ovf_seen,
  output logic [15:0]     ch_seen
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [9:0] left_r;  // Quarter steps of the burst still to send
  // Pulses are two cycles high, two low, so the 2-FF sync never misses one
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      left_r   <= 10'h000;
      ovf_seen <= 16'h0000;
      ch_seen  <= 16'h0000;
    end else begin
      if (go) left_r <= {burst, 2'h0};
      else if (left_r != 10'h000) left_r <= left_r - 10'h001;
      if (evt_ovf) ovf_seen <= ovf_seen + 16'h0001;
      if (|evt_ch) ch_seen <= ch_seen + 16'h0001;
    end
  end
  // Line rests low between bursts
  assign evt_pin = left_r[1];
endmodule  // ccpt_route_model
`default_nettype wire

// ==== verification/testbench.sv ====
`default_nettype none
// ----------------------------------------------------------------
// Bench for the timer unit
// ----------------------------------------------------------------
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys = 1'h0, resetn = 1'h0, ce = 1'h1, go = 1'h0, rd_d = 1'h0;
  logic irq, evt_ovf, evt_pin;
  ccpt_pkg::ccpt_bus_t bus_req = '0;  // Register request
  logic [3:0] cap_pin = 4'h0, ch_out, dt_hi, dt_lo, evt_ch, u1_lo, u1_hi;
  logic [31:0] rdata;                 // Read answer
  logic [31:0] exp_q[$];              // Expected read data, oldest first
  logic [7:0] burst = 8'h00, a;
  logic [15:0] ovf_seen, ch_seen, n, v, vv[4];
  logic [7:0] ra[6] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'hFC};
  int fail_count = 0, checks_done = 0, t;
  always #5 clk_sys = ~clk_sys;
  // Unit zero under test; a wide unit one shares every input, counts alike and lacks dead-time
  ccpt_timer #(.CNT_W(16), .NUM_CH(4), .UNIT_ID(0)) i_dut (.clk_sys(clk_sys), .resetn(resetn), .ce(ce),
    .bus_req(bus_req), .rdata(rdata), .irq(irq), .cap_pin(cap_pin), .evt_pin(evt_pin), .ch_out(ch_out),
    .dt_hi(dt_hi), .dt_lo(dt_lo), .evt_ovf(evt_ovf), .evt_ch(evt_ch));
  ccpt_timer #(.CNT_W(32), .NUM_CH(4), .UNIT_ID(1)) i_unit1 (.clk_sys(clk_sys), .resetn(resetn), .ce(ce),
    .bus_req(bus_req), .rdata(), .irq(), .cap_pin(cap_pin), .evt_pin(evt_pin), .ch_out(),
    .dt_hi(u1_hi), .dt_lo(u1_lo), .evt_ovf(), .evt_ch());
  ccpt_route_model i_route (.clk_sys(clk_sys), .resetn(resetn), .evt_ovf(evt_ovf), .evt_ch(evt_ch),
    .burst(burst), .go(go), .evt_pin(evt_pin), .ovf_seen(ovf_seen), .ch_seen(ch_seen));
  // ----------------------------------------------------------------
  // Checking
  // ----------------------------------------------------------------
  task automatic cmp(input logic [31:0] g, input logic [31:0] e, input string w);
    checks_done++;
    if (g !== e) begin
      fail_count++;
      $display("Error at %0t: %s got %h want %h", $time, w, g, e);
    end
  endtask
  task automatic cmp_bit(input logic g, input logic e, input string w);
    cmp({31'h0, g}, {31'h0, e}, w);
  endtask
  // Read data stand only in the cycle after the strobe, so look exactly there
  always @(posedge clk_sys) begin
    if (rd_d && exp_q.size() == 0) cmp(rdata, 32'h0, "unexpected read");
    else if (rd_d) cmp(rdata, exp_q.pop_front(), "read data");
    rd_d <= bus_req.rd;
  end
  task automatic tally_and_finish();
    $display("Checks %0d, mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // ----------------------------------------------------------------
  // Bus tasks
  // ----------------------------------------------------------------
  task automatic tick(input int c);
    repeat (c) @(posedge clk_sys);
    #1;
  endtask
  task automatic wr(input logic [7:0] ad, input logic [31:0] d);
    @(posedge clk_sys);
    bus_req <= '{wr: 1'h1, rd: 1'h0, addr: ad, wdata: d};
    @(posedge clk_sys);
    bus_req.wr <= 1'h0;
  endtask
  task automatic rd(input logic [7:0] ad, input logic [31:0] e);
    exp_q.push_back(e);
    @(posedge clk_sys);
    bus_req <= '{wr: 1'h0, rd: 1'h1, addr: ad, wdata: 32'h0};
    @(posedge clk_sys);
    bus_req.rd <= 1'h0;
  endtask
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    void'($urandom(32'hE0C6FD6F));
    repeat (20) @(posedge clk_sys);
    resetn <= 1'h1;
    // Control, status, mask, count and dead-time registers and an unmapped place read zero after reset
    foreach (ra[j]) rd(ra[j], 32'h0);
    $display("test reset done");
    // Run for a random span; both edges of the stop write still tick, hence the two
    t = $urandom_range(200);
    n = 16'(t) + 16'h0002;
    wr(8'h00, 32'h1);
    repeat (t) @(posedge clk_sys);
    wr(8'h00, 32'h0);
    rd(8'h0C, {16'h0, n});
    $display("test count done");
    // Thresholds drawn at random from one below, at and one above the frozen count
    for (int i = 0; i < 4; i++) begin
      v = n - 16'h0001 + 16'($urandom_range(2));
      vv[i] = v;
      a = 8'h20 + 8'(8 * i);
      wr(a, 32'h2);
      wr(a + 8'h04, {16'h0, v});
      rd(a + 8'h04, {16'h0, v});
      tick(2);
      cmp_bit(ch_out[i], n >= v, "compare out");
    end
    cmp({28'h0, dt_hi ^ ch_out}, 32'h0, "pair hi");
    cmp({28'h0, dt_lo ^ ~ch_out}, 32'h0, "pair lo");
    cmp({28'h0, u1_lo}, 32'h0, "unit one pair");
    cmp({28'h0, u1_hi ^ ch_out}, 32'h0, "wide unit follows");
    $display("test compare done");
    // Dead band of len+1 cycles on a rising output
    wr(8'h10, 32'h3);
    wr(8'h24, 32'hFFFF);
    wr(8'h00, 32'h4);
    tick(8);
    wr(8'h24, 32'h0);
    tick(3);
    cmp({30'h0, dt_hi[0], dt_lo[0]}, 32'h0, "dead band");
    tick(8);
    cmp({30'h0, dt_hi[0], dt_lo[0]}, 32'h2, "after band");
    $display("test dead time done");
    // Rising capture on 0; rising edge ignored by falling-edge channel 1
    wr(8'h08, 32'h1F);
    wr(8'h20, 32'h1);
    wr(8'h28, 32'h5);
    wr(8'h2C, 32'h1234);
    cap_pin <= 4'h3;
    tick(8);
    rd(8'h24, {16'h0, n});
    rd(8'h2C, 32'h1234);
    rd(8'h04, 32'h2);
    cmp_bit(irq, 1'h1, "irq set");
    cmp({16'h0, ch_seen}, 32'h1, "routed channel event");
    // Five routed events advance the counter, then a falling capture
    wr(8'h00, 32'h3);
    burst <= 8'h05;
    go <= 1'h1;
    tick(1);
    go <= 1'h0;
    tick(30);
    wr(8'h00, 32'h0);
    rd(8'h0C, {16'h0, n + 16'h0005});
    cap_pin <= 4'h1;
    tick(8);
    rd(8'h2C, {16'h0, n + 16'h0005});
    // Channels 2 and 3 also match while counting if their threshold lies in the counted span
    rd(8'h04, {27'h0, vv[3] >= n, vv[2] >= n, 3'h6});
    wr(8'h04, 32'h1F);
    rd(8'h04, 32'h0);
    tick(2);
    cmp_bit(irq, 1'h0, "irq clear");
    $display("test capture done");
    // Full wrap: overflow trigger, and the PWM shadow loads at the wrap
    wr(8'h08, 32'h1);
    wr(8'h30, 32'h3);
    wr(8'h34, 32'h8000);
    tick(2);
    cmp_bit(ch_out[2], 1'h0, "pwm first period");
    wr(8'h00, 32'h1);
    for (t = 0; t < 70000 && irq !== 1'h1; t++) tick(1);
    if (irq !== 1'h1) begin
      cmp_bit(1'h0, 1'h1, "wrap timeout");
      tally_and_finish();
    end
    wr(8'h00, 32'h0);
    tick(2);
    cmp({16'h0, ovf_seen}, 32'h1, "overflow trigger");
    cmp_bit(ch_out[2], 1'h1, "pwm high");
    wr(8'h04, 32'h1);
    tick(2);
    cmp_bit(irq, 1'h0, "overflow clear");
    $display("test wrap done");
    // Clock enable low for ten edges: only the two edges of the stop write after it count
    wr(8'h00, 32'h1);
    ce <= 1'h0;
    repeat (10) @(posedge clk_sys);
    ce <= 1'h1;
    wr(8'h00, 32'h0);
    rd(8'h0C, 32'h4);
    $display("test clock enable done");
    tick(3);
    tally_and_finish();
  end
endmodule  // testbench
`default_nettype wire
